/* core/pldm_defines.svh */
/*
  Constants of the programmable logic block: product term layout of the decode
  and complex arrays, the layout of the array input vector and pin masks.
  Assumes it is included by bare name from the package and the design modules.
*/
// Behaviour
// RULE1 - Decode array gives eight primary flash sector selects, each OR of three terms.
// RULE2 - Decode array gives four secondary flash sector selects, each OR of three terms.
// RULE3 - Decode array gives one SRAM select, OR of at most two terms.
// RULE4 - Decode array gives one select for the module register block window.
// RULE5 - Two peripheral window selects, active only in peripheral port mode.
// RULE6 - Two external chip selects on port D from dedicated terms, no macrocell.
// RULE7 - Complex array: 20 input macrocells, 16 output macrocells, 137 terms.
// RULE8 - Core writes output macrocells and reads input and output macrocells.
// RULE9 - Group one routes to port A or B, group two to B or C.
// RULE10 - Unassigned macrocell output is placed on one of its group's ports.
// RULE11 - Each output macrocell has an XOR polarity stage on its sum.
// RULE12 - Each output macrocell muxes registered or combinational result.
// RULE13 - Selected output drives a pin and feeds back into the AND array.
// RULE14 - Macrocell flip-flop acts as D, T, JK or SR type.
// RULE15 - Clock, preset, clear from terms; clock may come from clock-in pin.
// RULE16 - With clock-in selected, flip-flop updates on that pin's rising edge.
// RULE17 - Preset and clear are active high; preset sets, clear resets.
// RULE18 - Each clear input is the OR of up to two terms.
// RULE19 - Group one cells own three terms and borrow up to six more.
// RULE20 - Core write to a macrocell overrides its clock, preset and clear.
// RULE21 - Macrocell n of either group maps to data bus bit n.
`ifndef PLDM_DEFINES_SVH
`define PLDM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Array input vector
// ----------------------------------------------------------------------------
`define PLDM_IN_W 69
`define PLDM_IN_ADDR 0
`define PLDM_IN_CTRL 16
`define PLDM_IN_RST 20
`define PLDM_IN_PDN 21
`define PLDM_IN_IMC 22
`define PLDM_IN_PORTD 42
`define PLDM_IN_PAGE 44
`define PLDM_IN_FB 52
`define PLDM_IN_RDY 68

// ----------------------------------------------------------------------------
// Complex array product terms
// ----------------------------------------------------------------------------
`define PLDM_PT_N 137
`define PLDM_PT_NATIVE 0
`define PLDM_PT_POOL_N 71
`define PLDM_PT_CLK 71
`define PLDM_PT_PRE 87
`define PLDM_PT_CLR 103
`define PLDM_PT_ECS 135
`define PLDM_NATIVE_G1 3
`define PLDM_NATIVE_G2 4
`define PLDM_G2_BASE 24
`define PLDM_BORROW_G1 6
`define PLDM_BORROW_G2LO 5
`define PLDM_BORROW_G2HI 6
`define PLDM_BORROW_MAX 6
`define PLDM_OMC_N 16
`define PLDM_IMC_N 20

// ----------------------------------------------------------------------------
// Decode array product terms
// ----------------------------------------------------------------------------
`define PLDM_DEC_N 41
`define PLDM_DEC_PRI 0
`define PLDM_DEC_SEC 24
`define PLDM_DEC_SRAM 36
`define PLDM_DEC_REG 38
`define PLDM_DEC_PERI 39

// Port C pins that can carry a macrocell output (2, 3, 4, 7)
`define PLDM_PC_AVAIL 8'h9C

`endif

/* core/pldm_omc.sv */
/*
  One output macrocell: polarity stage, configurable flip-flop with core load,
  preset and clear, and the registered/combinational output mux.
  Assumes sums, clock terms and the clock-in edge come from the array in the top.
*/
`include "pldm_defines.svh"
module pldm_omc (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sumSet,
  input wire logic sumReset,
  input wire logic polInvert,
  input wire pldm_pkg::pldm_ff_e ffType,
  input wire logic combSel,
  input wire logic extClkSel,
  input wire logic ptClk,
  input wire logic extClkRise,
  input wire logic preset,
  input wire logic clear,
  input wire logic load,
  input wire logic loadData,
  output logic q,
  output logic cellOut
);
  import pldm_pkg::*;

  logic ptClkPrev;
  logic next_q;
  logic next_cellOut;
  logic dv;
  logic jk;
  logic clkEvent;

  // ----------------------------------------------------------------------------
  // Next state of the storage element
  // ----------------------------------------------------------------------------
  always_comb begin
    dv = polInvert ^ (sumSet | sumReset); // [RULE11]
    jk = polInvert ^ sumSet; // [RULE11]
    clkEvent = extClkSel ? extClkRise : (ptClk & ~ptClkPrev); // [RULE15] [RULE16]
    next_q = q;
    if (load) begin
      next_q = loadData; // [RULE20]
    end else if (clear) begin
      next_q = 1'b0; // [RULE17]
    end else if (preset) begin
      next_q = 1'b1; // [RULE17]
    end else if (clkEvent) begin
      // Native sum drives J or S, borrowed sum drives K or R
      case (ffType) // [RULE14]
        PLDM_FF_D: next_q = dv;
        PLDM_FF_T: next_q = q ^ dv;
        PLDM_FF_JK: next_q = (jk & ~q) | (~sumReset & q);
        PLDM_FF_SR: next_q = (jk & ~sumReset) ? 1'b1 : ((sumReset & ~jk) ? 1'b0 : q);
        default: next_q = q;
      endcase
    end
    // Combinational path is registered to break loops through feedback
    next_cellOut = combSel ? dv : next_q; // [RULE12]
  end

  // Registers of the macrocell
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= 1'b0;
      cellOut <= 1'b0;
      ptClkPrev <= 1'b0;
    end else begin
      q <= next_q;
      cellOut <= next_cellOut;
      ptClkPrev <= ptClk;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_quiet;
    !load && !clear && !preset;
  endsequence
  sequence s_ext_d_edge;
    s_quiet ##0 extClkSel && extClkRise && ffType == PLDM_FF_D;
  endsequence

  a_load_over_clear: assert property (load |=> q == $past(loadData)) // [RULE20]
    else $error("core load did not win");
  a_clear_forces_zero: assert property (!load && clear |=> !q) // [RULE17]
    else $error("clear did not reset flip-flop");
  a_preset_forces_one: assert property (!load && !clear && preset |=> q) // [RULE17]
    else $error("preset did not set flip-flop");
  a_ext_clock_d: assert property (s_ext_d_edge |=> q == $past(dv)) // [RULE16]
    else $error("clock-in edge did not load D");
  a_ext_no_edge: assert property (s_quiet ##0 extClkSel && !extClkRise |=> q == $past(q)) // [RULE16]
    else $error("flip-flop moved without clock-in edge");
  a_toggle_flips: assert property (s_quiet ##0 extClkSel && extClkRise && ffType == PLDM_FF_T && dv
    |=> q != $past(q)) // [RULE14]
    else $error("T flip-flop did not toggle");
  a_comb_select: assert property (combSel |=> cellOut == $past(dv)) // [RULE12]
    else $error("combinational output not selected");
endmodule

/* core/pldm_pkg.sv */
/*
  Types and the product term evaluator shared by the logic block modules.
  Assumes the defines header is on the include path.
*/
`include "pldm_defines.svh"
package pldm_pkg;
  typedef enum logic [3:0] {PLDM_FF_D = 4'h1, PLDM_FF_T = 4'h2, PLDM_FF_JK = 4'h4, PLDM_FF_SR = 4'h8} pldm_ff_e;
  typedef enum logic [4:0] {PLDM_TGT_OMC1 = 5'h01, PLDM_TGT_OMC2 = 5'h02, PLDM_TGT_IMCA = 5'h04,
    PLDM_TGT_IMCB = 5'h08, PLDM_TGT_IMCC = 5'h10} pldm_tgt_e;
  typedef logic [`PLDM_IN_W-1:0] pldm_in_t;
  typedef logic [`PLDM_PT_N-1:0][`PLDM_IN_W-1:0] pldm_pt_cfg_t;
  typedef logic [`PLDM_DEC_N-1:0][`PLDM_IN_W-1:0] pldm_dec_cfg_t;
  typedef logic [`PLDM_OMC_N-1:0][`PLDM_BORROW_MAX-1:0][6:0] pldm_bidx_t;

  // A term with no literal programmed stays low, as an erased array cell does
  function automatic logic pldm_term(input pldm_in_t inV, input pldm_in_t tm, input pldm_in_t cm);
    return (|(tm | cm)) & (&((~tm | inV) & (~cm | ~inV)));
  endfunction
endpackage

/* core/pldm_top.sv */
/*
  Programmable logic of the memory module: decode array selects, complex array
  with 16 output macrocells, input macrocell sampling, port routing and core access.
  Assumes configuration ports are static after reset and pins are synchronous.
*/
`include "pldm_defines.svh"
module pldm_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [15:0] mcuAddr,
  input wire logic [3:0] mcuCtrl,
  input wire logic rstIn,
  input wire logic powerDown,
  input wire logic [7:0] pageReg,
  input wire logic flashReady,
  input wire logic pioMode,
  input wire logic [7:0] portAIn,
  input wire logic [7:0] portBIn,
  input wire logic [7:0] portCIn,
  input wire logic externalClockIn,
  input wire logic portDBitTwo,
  input wire pldm_pkg::pldm_dec_cfg_t decTrue,
  input wire pldm_pkg::pldm_dec_cfg_t decComp,
  input wire pldm_pkg::pldm_pt_cfg_t ptTrue,
  input wire pldm_pkg::pldm_pt_cfg_t ptComp,
  input wire logic [15:0][3:0] nativeUse,
  input wire logic [15:0][5:0] borrowEn,
  input wire pldm_pkg::pldm_bidx_t borrowIdx,
  input wire logic [15:0] polInvert,
  input wire pldm_pkg::pldm_ff_e [15:0] ffType,
  input wire logic [15:0] combSel,
  input wire logic [15:0] extClkSel,
  input wire logic [15:0] pinAssigned,
  input wire logic [15:0] pinSecond,
  input wire logic [15:0] cellOutEn,
  input wire logic [1:0] ecsEn,
  input wire logic coreWrite,
  input wire logic coreRead,
  input wire pldm_pkg::pldm_tgt_e coreSel,
  input wire logic [7:0] coreWData,
  output logic [7:0] coreRData,
  output logic [7:0] primarySectorSelect,
  output logic [3:0] secondarySectorSelect,
  output logic sramSelect,
  output logic moduleRegisterSelect,
  output logic [1:0] peripheralSelect,
  output logic [7:0] portAOut,
  output logic [7:0] portAOe,
  output logic [7:0] portBOut,
  output logic [7:0] portBOe,
  output logic [7:0] portCOut,
  output logic [7:0] portCOe,
  output logic [1:0] externalChipSelect,
  output logic [1:0] externalChipSelectOe
);
  import pldm_pkg::*;

  pldm_in_t pldIn;
  logic [`PLDM_PT_N-1:0] pt;
  logic [`PLDM_DEC_N-1:0] dt;
  logic [`PLDM_IMC_N-1:0] imcState;
  logic [`PLDM_IMC_N-1:0] next_imcState;
  logic extClkPrev;
  logic extClkRise;
  logic [15:0] q;
  logic [15:0] cellOut;
  logic [15:0] sumSet;
  logic [15:0] sumReset;
  logic [15:0] cellLoad;
  logic [`PLDM_PT_POOL_N-1:0] claimed;
  logic [7:0] next_coreRData;
  logic [7:0] next_primary;
  logic [3:0] next_secondary;
  logic next_sram;
  logic next_modReg;
  logic [1:0] next_periph;
  logic [7:0] next_portAOut;
  logic [7:0] next_portAOe;
  logic [7:0] next_portBOut;
  logic [7:0] next_portBOe;
  logic [7:0] next_portCOut;
  logic [7:0] next_portCOe;
  logic [1:0] next_ecs;
  logic [1:0] next_ecsOe;
  localparam logic [7:0] pcAvail = `PLDM_PC_AVAIL;

  // ----------------------------------------------------------------------------
  // AND array inputs and product terms
  // ----------------------------------------------------------------------------
  // Macrocell feedback is the registered output, so no loop is formed
  always_comb begin
    pldIn = '0;
    pldIn[`PLDM_IN_ADDR +: 16] = mcuAddr;
    pldIn[`PLDM_IN_CTRL +: 4] = mcuCtrl;
    pldIn[`PLDM_IN_RST] = rstIn;
    pldIn[`PLDM_IN_PDN] = powerDown;
    pldIn[`PLDM_IN_IMC +: `PLDM_IMC_N] = imcState;
    pldIn[`PLDM_IN_PORTD +: 2] = {portDBitTwo, externalClockIn};
    pldIn[`PLDM_IN_PAGE +: 8] = pageReg;
    pldIn[`PLDM_IN_FB +: 16] = cellOut; // [RULE13]
    pldIn[`PLDM_IN_RDY] = flashReady;
  end

  // Complex array terms and decode array terms
  for (genvar t = 0; t < `PLDM_PT_N; t++) begin : gTerm
    assign pt[t] = pldm_term(pldIn, ptTrue[t], ptComp[t]); // [RULE7]
  end
  for (genvar t = 0; t < `PLDM_DEC_N; t++) begin : gDec
    assign dt[t] = pldm_term(pldIn, decTrue[t], decComp[t]);
  end

  // ----------------------------------------------------------------------------
  // Decode array selects
  // ----------------------------------------------------------------------------
  always_comb begin
    for (int s = 0; s < 8; s++) begin
      next_primary[s] = |dt[`PLDM_DEC_PRI + 3 * s +: 3]; // [RULE1]
    end
    for (int s = 0; s < 4; s++) begin
      next_secondary[s] = |dt[`PLDM_DEC_SEC + 3 * s +: 3]; // [RULE2]
    end
    next_sram = |dt[`PLDM_DEC_SRAM +: 2]; // [RULE3]
    next_modReg = dt[`PLDM_DEC_REG]; // [RULE4]
    // Peripheral windows stay quiet outside peripheral port mode
    next_periph = pioMode ? dt[`PLDM_DEC_PERI +: 2] : 2'h0; // [RULE5]
  end

  // Decode select registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      primarySectorSelect <= 8'h00;
      secondarySectorSelect <= 4'h0;
      sramSelect <= 1'b0;
      moduleRegisterSelect <= 1'b0;
      peripheralSelect <= 2'h0;
    end else begin
      primarySectorSelect <= next_primary;
      secondarySectorSelect <= next_secondary;
      sramSelect <= next_sram;
      moduleRegisterSelect <= next_modReg;
      peripheralSelect <= next_periph;
    end
  end

  // ----------------------------------------------------------------------------
  // Product term sums with borrowing
  // ----------------------------------------------------------------------------
  // A borrowed term counts only while its owner leaves it unused
  always_comb begin
    int base;
    int cnt;
    int slots;
    int idx;
    base = 0;
    cnt = 0;
    slots = 0;
    idx = 0;
    claimed = '0;
    sumSet = '0;
    sumReset = '0;
    for (int c = 0; c < `PLDM_OMC_N; c++) begin
      base = (c < 8) ? `PLDM_NATIVE_G1 * c : `PLDM_G2_BASE + `PLDM_NATIVE_G2 * (c - 8);
      cnt = (c < 8) ? `PLDM_NATIVE_G1 : `PLDM_NATIVE_G2;
      for (int k = 0; k < 4; k++) begin
        if (k < cnt) begin
          claimed[base + k] = nativeUse[c][k];
          sumSet[c] = sumSet[c] | (nativeUse[c][k] & pt[base + k]); // [RULE19]
        end
      end
    end
    for (int c = 0; c < `PLDM_OMC_N; c++) begin
      slots = (c < 8) ? `PLDM_BORROW_G1 : ((c < 12) ? `PLDM_BORROW_G2LO : `PLDM_BORROW_G2HI);
      for (int s = 0; s < `PLDM_BORROW_MAX; s++) begin
        idx = int'(borrowIdx[c][s]);
        if (s < slots && borrowEn[c][s] && idx < `PLDM_PT_POOL_N) begin
          if (!claimed[idx]) begin
            sumReset[c] = sumReset[c] | pt[idx]; // [RULE19]
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Output macrocells
  // ----------------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < `PLDM_OMC_N; c++) begin
      cellLoad[c] = coreWrite && (coreSel == ((c < 8) ? PLDM_TGT_OMC1 : PLDM_TGT_OMC2)); // [RULE8]
    end
  end

  assign extClkRise = externalClockIn & ~extClkPrev; // [RULE16]

  for (genvar c = 0; c < `PLDM_OMC_N; c++) begin : gCell
    pldm_omc uCell (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .sumSet(sumSet[c]),
      .sumReset(sumReset[c]),
      .polInvert(polInvert[c]),
      .ffType(ffType[c]),
      .combSel(combSel[c]),
      .extClkSel(extClkSel[c]),
      .ptClk(pt[`PLDM_PT_CLK + c]), // [RULE15]
      .extClkRise(extClkRise),
      .preset(pt[`PLDM_PT_PRE + c]), // [RULE15]
      .clear(pt[`PLDM_PT_CLR + 2 * c] | pt[`PLDM_PT_CLR + 2 * c + 1]), // [RULE18]
      .load(cellLoad[c]),
      .loadData(coreWData[c % 8]), // [RULE21]
      .q(q[c]),
      .cellOut(cellOut[c])
    );
  end

  // ----------------------------------------------------------------------------
  // Input macrocells and core read-back
  // ----------------------------------------------------------------------------
  // Read data hold their last value between reads
  always_comb begin
    next_imcState = {portCIn[7], portCIn[4:2], portBIn, portAIn};
    next_coreRData = coreRData;
    if (coreRead) begin
      case (coreSel) // [RULE8] [RULE21]
        PLDM_TGT_OMC1: next_coreRData = q[7:0];
        PLDM_TGT_OMC2: next_coreRData = q[15:8];
        PLDM_TGT_IMCA: next_coreRData = imcState[7:0];
        PLDM_TGT_IMCB: next_coreRData = imcState[15:8];
        PLDM_TGT_IMCC: next_coreRData = {imcState[19], 2'h0, imcState[18:16], 2'h0};
        default: next_coreRData = 8'h00;
      endcase
    end
  end

  // Input sampling, clock-in history and read data
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      imcState <= '0;
      extClkPrev <= 1'b0;
      coreRData <= 8'h00;
    end else begin
      imcState <= next_imcState;
      extClkPrev <= externalClockIn;
      coreRData <= next_coreRData;
    end
  end

  // ----------------------------------------------------------------------------
  // Port routing and external chip selects
  // ----------------------------------------------------------------------------
  // Unassigned cells go to port A or C; port C holes fall back to B
  always_comb begin
    logic toB1;
    logic toC2;
    toB1 = 1'b0;
    toC2 = 1'b0;
    for (int n = 0; n < 8; n++) begin
      toB1 = pinAssigned[n] & pinSecond[n]; // [RULE9] [RULE10]
      toC2 = (pinAssigned[n + 8] ? pinSecond[n + 8] : 1'b1) & pcAvail[n]; // [RULE10]
      next_portAOut[n] = cellOut[n]; // [RULE13]
      next_portAOe[n] = cellOutEn[n] & ~toB1; // [RULE9]
      next_portCOut[n] = cellOut[n + 8];
      next_portCOe[n] = cellOutEn[n + 8] & toC2; // [RULE9]
      // Group one wins a port B pin that both groups claim
      if (toB1 && cellOutEn[n]) begin
        next_portBOut[n] = cellOut[n];
        next_portBOe[n] = 1'b1;
      end else begin
        next_portBOut[n] = cellOut[n + 8];
        next_portBOe[n] = cellOutEn[n + 8] & ~toC2;
      end
    end
    next_ecs = pt[`PLDM_PT_ECS +: 2]; // [RULE6]
    next_ecsOe = ecsEn; // [RULE6]
  end

  // Pin registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      portAOut <= 8'h00;
      portAOe <= 8'h00;
      portBOut <= 8'h00;
      portBOe <= 8'h00;
      portCOut <= 8'h00;
      portCOe <= 8'h00;
      externalChipSelect <= 2'h0;
      externalChipSelectOe <= 2'h0;
    end else begin
      portAOut <= next_portAOut;
      portAOe <= next_portAOe;
      portBOut <= next_portBOut;
      portBOe <= next_portBOe;
      portCOut <= next_portCOut;
      portCOe <= next_portCOe;
      externalChipSelect <= next_ecs;
      externalChipSelectOe <= next_ecsOe;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_primary_decode: assert property (##1 primarySectorSelect[0] == $past(|dt[2:0])) // [RULE1]
    else $error("primary select not OR of its terms");
  a_secondary_decode: assert property (##1 secondarySectorSelect[3] == $past(|dt[35:33])) // [RULE2]
    else $error("secondary select not OR of its terms");
  a_sram_decode: assert property (##1 sramSelect == $past(dt[36] | dt[37])) // [RULE3]
    else $error("SRAM select wrong");
  a_periph_gated: assert property (!pioMode |=> peripheralSelect == 2'h0) // [RULE5]
    else $error("peripheral select outside peripheral mode");
  a_ecs_follows: assert property (##1 externalChipSelect == $past(pt[136:135])) // [RULE6]
    else $error("external chip select wrong");
  a_readback_map: assert property (coreRead && coreSel == PLDM_TGT_OMC2 |=> coreRData == $past(q[15:8])) // [RULE21]
    else $error("group two read-back misaligned");
  a_load_then_read: assert property (coreWrite && coreSel == PLDM_TGT_OMC1 ##1 coreRead && coreSel == PLDM_TGT_OMC1
    |=> coreRData == $past(coreWData, 2)) // [RULE20]
    else $error("loaded value not read back");
  a_default_route: assert property (cellOutEn[0] && !pinAssigned[0] // [RULE10]
    |=> portAOe[0] && portAOut[0] == $past(cellOut[0]))
    else $error("unassigned group one cell not on port A");
endmodule

/* verif/pld_decode_and_output_macrocells_test.sv */
/*
  Self-checking bench for pldm_top: decode selects, macrocell load, read, clocks and pins.
  Assumes the core model drives the bus side; configuration is set at time zero and changed between later checks.
*/
module pld_decode_and_output_macrocells_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pldm_pkg::*;
  typedef struct {logic [15:0] addr; logic pio; logic [15:0] exp;} pldm_row_s;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic rstIn = 1'b0, powerDown = 1'b0, flashReady = 1'b0, pioMode = 1'b0, externalClockIn = 1'b0;
  logic portDBitTwo = 1'b0;
  logic [7:0] pageReg = 8'h00, portAIn = 8'h00, portBIn = 8'h00, portCIn = 8'h00;
  logic [15:0] mcuAddr;
  logic [3:0] mcuCtrl, secondarySectorSelect;
  logic coreWrite, coreRead, sramSelect, moduleRegisterSelect;
  pldm_tgt_e coreSel;
  logic [7:0] coreWData, coreRData, primarySectorSelect, portAOut, portAOe, portBOut, portBOe, portCOut, portCOe, rd;
  logic [1:0] peripheralSelect, externalChipSelect, externalChipSelectOe, ecsEn = 2'h3;
  pldm_dec_cfg_t decTrue = '0, decComp = '0;
  pldm_pt_cfg_t ptTrue = '0, ptComp = '0;
  logic [15:0][3:0] nativeUse = '1;
  logic [15:0][5:0] borrowEn = '0;
  pldm_bidx_t borrowIdx = '0;
  logic [15:0] polInvert = '0, combSel = '0, extClkSel = 16'h0002, pinAssigned = '0, pinSecond = '0, cellOutEn = '1;
  pldm_ff_e [15:0] ffType = {16{PLDM_FF_D}};
  pldm_row_s rows [32];
  int mismatches = 0, totalChecks = 0;
  wire [15:0] decAll = {peripheralSelect, moduleRegisterSelect, sramSelect, secondarySectorSelect, primarySectorSelect};
  // 100 ns clock
  always #50 clk_sys = ~clk_sys;
  pldm_core_model core (.clk_sys, .coreRData, .mcuAddr, .mcuCtrl, .coreWrite, .coreRead, .coreSel, .coreWData);
  pldm_top DUT (.clk_sys, .arst_n, .mcuAddr, .mcuCtrl, .rstIn, .powerDown, .pageReg, .flashReady, .pioMode, .portAIn,
    .portBIn, .portCIn, .externalClockIn, .portDBitTwo, .decTrue, .decComp, .ptTrue, .ptComp, .nativeUse, .borrowEn,
    .borrowIdx, .polInvert, .ffType, .combSel, .extClkSel, .pinAssigned, .pinSecond, .cellOutEn, .ecsEn, .coreWrite,
    .coreRead, .coreSel, .coreWData, .coreRData, .primarySectorSelect, .secondarySectorSelect, .sramSelect,
    .moduleRegisterSelect, .peripheralSelect, .portAOut, .portAOe, .portBOut, .portBOe, .portCOut, .portCOe,
    .externalChipSelect, .externalChipSelectOe);
  // Compare and count; case inequality so an unknown never matches
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One clean rising edge on the clock-in pin
  task automatic ext_pulse;
    externalClockIn = 1'b0;
    tick(1);
    externalClockIn = 1'b1;
    tick(1);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------------------
  initial begin
    // Selects use a later term of their sum, so a first-term-only OR shows up
    for (int s = 0; s < 8; s++) decTrue[3*s+2][s] = 1'b1;
    for (int s = 0; s < 4; s++) decTrue[24+3*s+1][8+s] = 1'b1;
    decTrue[37][12] = 1'b1;
    decTrue[38][13] = 1'b1;
    decTrue[39][14] = 1'b1;
    decTrue[40][15] = 1'b1;
    // Page bits steer cell 0 data/clock, cell 1 data, cell 2 preset/clear, select 0
    ptTrue[0][44] = 1'b1;
    ptTrue[71][45] = 1'b1;
    ptTrue[3][44] = 1'b1;
    ptTrue[89][46] = 1'b1;
    ptTrue[108][47] = 1'b1;
    ptTrue[135][48] = 1'b1;
    for (int i = 0; i < 32; i++) begin
      rows[i].addr = 16'h0001 << (i % 16);
      rows[i].pio = i[4];
      rows[i].exp = {rows[i].addr[15:14] & {2{rows[i].pio}}, rows[i].addr[13:0]};
    end
    tick(3);
    check("outputs in reset", 16'h0000, {portAOut, primarySectorSelect});
    arst_n = 1'b1;
    foreach (rows[i]) begin
      pioMode = rows[i].pio;
      core.set_addr(rows[i].addr);
      tick(1);
      check("decode selects", rows[i].exp, decAll);
    end
    core.load(PLDM_TGT_OMC1, 8'hA5, 1);
    core.fetch(PLDM_TGT_OMC1, rd);
    check("group one read", 16'h00A5, {8'h00, rd});
    check("port A pins", 16'hA5FF, {portAOut, portAOe});
    core.load(PLDM_TGT_OMC2, 8'h5A, 1);
    core.fetch(PLDM_TGT_OMC2, rd);
    check("group two read", 16'h005A, {8'h00, rd});
    check("port B pins", 16'h4263, {portBOut & 8'h63, portBOe});
    check("port C pins", 16'h189C, {portCOut & 8'h9C, portCOe});
    // Rising clock term with data high sets cell 0 only
    core.load(PLDM_TGT_OMC1, 8'h00, 1);
    pageReg = 8'h01;
    tick(2);
    pageReg = 8'h03;
    tick(2);
    core.fetch(PLDM_TGT_OMC1, rd);
    check("term clock", 16'h0001, {8'h00, rd});
    externalClockIn = 1'b1;
    tick(2);
    core.fetch(PLDM_TGT_OMC1, rd);
    check("clock-in edge", 16'h0003, {8'h00, rd});
    pageReg = 8'h07;
    tick(2);
    core.fetch(PLDM_TGT_OMC1, rd);
    check("preset", 16'h0007, {8'h00, rd});
    pageReg = 8'h0F;
    tick(2);
    core.fetch(PLDM_TGT_OMC1, rd);
    check("clear over preset", 16'h0003, {8'h00, rd});
    // Load wins while clear is held, then clear takes the cell back
    core.load(PLDM_TGT_OMC1, 8'h07, 1);
    tick(1);
    check("load over clear", 16'h0007, {8'h00, portAOut});
    tick(1);
    check("clear after load", 16'h0003, {8'h00, portAOut});
    pageReg = 8'h10;
    tick(1);
    check("external selects", 16'h000D, {12'h000, externalChipSelectOe, externalChipSelect});
    // Input macrocells read back; port C keeps only pins 7 and 4..2
    portAIn = 8'h3C;
    portCIn = 8'hFF;
    core.fetch(PLDM_TGT_IMCA, rd);
    check("input A read", 16'h003C, {8'h00, rd});
    core.fetch(PLDM_TGT_IMCC, rd);
    check("input C read", 16'h009C, {8'h00, rd});
    // Inverted empty sum on the combinational path drives the pin high
    polInvert[3] = 1'b1;
    combSel[3] = 1'b1;
    tick(2);
    check("inverted comb pin", 16'h0008, {8'h00, portAOut & 8'h08});
    // Borrowed spare term is K: J and K high toggle cell 1 low, then T toggles it back
    ptTrue[56][44] = 1'b1;
    borrowEn[1][0] = 1'b1;
    borrowIdx[1][0] = 7'h38;
    ffType[1] = PLDM_FF_JK;
    pageReg = 8'h01;
    ext_pulse();
    core.fetch(PLDM_TGT_OMC1, rd);
    check("JK with borrowed K", 16'h0001, {8'h00, rd});
    ffType[1] = PLDM_FF_T;
    ext_pulse();
    core.fetch(PLDM_TGT_OMC1, rd);
    check("T toggle", 16'h0003, {8'h00, rd});
    pinAssigned[0] = 1'b1;
    pinSecond[0] = 1'b1;
    tick(1);
    check("cell 0 to port B", 16'h0003, {13'h0000, portAOe[0], portBOe[0], portBOut[0]});
    complete_run();
  end
endmodule

/* verif/pldm_core_model.sv */
/*
  Core-side model: address levels plus macrocell load and read strobes.
  Assumes callers enter its tasks just after a rising edge of clk_sys.
*/
module pldm_core_model (
  input wire logic clk_sys,
  input wire logic [7:0] coreRData,
  output logic [15:0] mcuAddr,
  output logic [3:0] mcuCtrl,
  output logic coreWrite,
  output logic coreRead,
  output pldm_pkg::pldm_tgt_e coreSel,
  output logic [7:0] coreWData
);
  timeunit 1ns;
  timeprecision 1ns;
  import pldm_pkg::*;
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // Idle bus: strobes low, control levels quiet
  initial begin
    mcuAddr = 16'h0000;
    mcuCtrl = 4'h0;
    coreWrite = 1'b0;
    coreRead = 1'b0;
    coreSel = PLDM_TGT_OMC1;
    coreWData = 8'h00;
  end
  // Address moves just after an edge so decode sees a clean level
  task automatic set_addr(input logic [15:0] a);
    @(posedge clk_sys);
    #1 mcuAddr = a;
  endtask
  // Level load held n edges; group and data stay put until the strobe drops
  task automatic load(input pldm_tgt_e g, input logic [7:0] d, input int n);
    @(posedge clk_sys);
    #1;
    coreSel = g;
    coreWData = d;
    coreWrite = 1'b1;
    repeat (n) @(posedge clk_sys);
    #1 coreWrite = 1'b0;
  endtask
  // One-edge read; data is registered at that edge
  task automatic fetch(input pldm_tgt_e g, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    coreSel = g;
    coreRead = 1'b1;
    @(posedge clk_sys);
    #1 coreRead = 1'b0;
    d = coreRData;
  endtask
endmodule
